// ==== hw/mhic_line_buffer.sv ====
/*
 * Four byte line buffer for host mailbox reads: reading byte 0 of a group, or any byte
 * outside the buffered group, latches the aligned group holding it; later reads of bytes 1-3 of that group come from the buffer.
 * Assumes the mailbox array is presented flat and sampled on i_clk.
 */
`timescale 1ns/1ps
module mhic_line_buffer
    import mhic_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [MHIC_MB_COUNT*8-1:0] i_mailboxes,
    input wire logic i_rd,
    input wire logic [MHIC_MB_AW-1:0] i_rd_addr,
    output logic [7:0] o_rd_data
);
    typedef struct packed {
        logic valid;
        logic [MHIC_MB_AW-MHIC_LINE_AW-1:0] line;
        logic [MHIC_LINE_BYTES*8-1:0] data;
        logic [7:0] rd_data;
    } mhic_lb_s;

    mhic_lb_s state_reg;
    mhic_lb_s state_next;

    function automatic logic [7:0] mb_byte(input logic [MHIC_MB_COUNT*8-1:0] mbs,
                                           input logic [MHIC_MB_AW-1:0] idx);
        mb_byte = mbs[idx*8 +: 8];
    endfunction

    always_comb begin
        logic [MHIC_MB_AW-MHIC_LINE_AW-1:0] line;
        logic [MHIC_LINE_AW-1:0] lane;
        line = i_rd_addr[MHIC_MB_AW-1:MHIC_LINE_AW];
        lane = i_rd_addr[MHIC_LINE_AW-1:0];
        state_next = state_reg;
        if (i_rd) begin
            if (state_reg.valid && state_reg.line == line && lane != '0) begin
                state_next.rd_data = state_reg.data[lane*8 +: 8];
            end else begin
                state_next.valid = 1'b1;
                state_next.line = line;
                for (int b = 0; b < MHIC_LINE_BYTES; b++) begin
                    state_next.data[b*8 +: 8] = mb_byte(i_mailboxes, {line, b[MHIC_LINE_AW-1:0]});
                end
                state_next.rd_data = mb_byte(i_mailboxes, i_rd_addr);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rd_data = state_reg.rd_data;
endmodule // mhic_line_buffer

// ==== hw/mhic_pkg.sv ====
/*
 * Shared constants for the mailbox host interrupt control block: the control
 * configuration byte layout, mailbox geometry and line buffer sizing.
 * Assumes a single clock domain; no other package is needed.
 */
package mhic_pkg;
    // ******************************************************************
    // mailbox geometry
    // ******************************************************************
    localparam int MHIC_MB_COUNT = 32;
    localparam int MHIC_MB_AW = 5;
    localparam int MHIC_LINE_BYTES = 4;
    localparam int MHIC_LINE_AW = 2;
    localparam int MHIC_CFG_AW = 6;
    // control configuration byte offset in the mailbox application input buffer
    localparam logic [5:0] MHIC_CTRL_CFG_OFFSET = 6'h38;
    localparam logic [7:0] MHIC_CTRL_CFG_RESET = 8'h00;
    // ******************************************************************
    // control configuration fields
    // ******************************************************************
    localparam int MHIC_BIT_INT_EN = 0;
    localparam int MHIC_BIT_INT_POL = 1;
    localparam int MHIC_BIT_STREAM = 2;
    localparam logic [7:0] MHIC_CTRL_CFG_MASK = 8'h07;
    localparam logic [7:0] MHIC_BYTE_ZERO = 8'h00;
    // ******************************************************************
    // pin mux selection
    // ******************************************************************
    typedef enum logic [0:0] {
        MHIC_PIN_GPIO = 1'b0,
        MHIC_PIN_IRQ = 1'b1
    } mhic_pin_e;
endpackage

// ==== hw/mhic_top.sv ====
/*
 * Mailbox host interrupt control.
 * Holds:
 *   - the control configuration byte at input buffer offset 56, with its
 *     registered readback (bits 3-7 always read as zero)
 *   - the 32 mailbox bytes written by the on-chip application, with the
 *     streaming gate that drops quick-read updates while streaming is off
 *   - a level pending flag toward the host, raised by a landed mailbox
 *     write while interrupts are on, cleared by an ack or by disabling
 *   - the pin mux between the GPIO function and the interrupt output,
 *     with the interrupt level following the polarity bit
 *   - the four byte line buffer that serves host mailbox reads
 * Assumes:
 *   - one clock, i_clk, and an asynchronous active-low reset
 *   - all strobes synchronous to i_clk and one cycle wide per access
 *   - i_app_quick_read flags the target mailbox of the same write
 *   - the GPIO block supplies the pin drive while the pin is not muxed
 *     to the interrupt, and the pin pad honours o_pin_oe_n
 *   - the host acks a pending interrupt through i_host_irq_ack
 */
// Operation
// - interrupts disabled after reset
// - bit 0 enables host interrupt
// - enabled: application mailbox write interrupts host
// - pin is GPIO after reset
// - enable switches pin to interrupt
// - disable returns pin to GPIO
// - bit 1 selects interrupt polarity
// - streaming off ignores quick-read updates
// - bit 2 enables streaming updates
// - control byte at input offset 56
// - host reads use aligned line buffer
`timescale 1ns/1ps
module mhic_top
    import mhic_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    // configuration input buffer access
    input wire logic i_cfg_wr,
    input wire logic [MHIC_CFG_AW-1:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata,
    // application mailbox writes
    input wire logic i_app_wr,
    input wire logic [MHIC_MB_AW-1:0] i_app_addr,
    input wire logic [7:0] i_app_wdata,
    input wire logic i_app_quick_read,
    // host mailbox reads
    input wire logic i_host_rd,
    input wire logic [MHIC_MB_AW-1:0] i_host_addr,
    output logic [7:0] o_host_rdata,
    // pin and gpio
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe_n,
    input wire logic i_host_irq_ack,
    output logic o_pin_out,
    output logic o_pin_oe_n,
    output logic o_pin_irq_mode,
    output logic o_stream_en
);
    // ******************************************************************
    // registered state
    // ******************************************************************
    typedef struct packed {
        // control byte, bits 3-7 held at zero
        logic [7:0] ctrl_byte;
        // level pending toward the host
        logic irq_pend;
        // mailbox bytes, mailbox 0 in the low byte
        logic [MHIC_MB_COUNT*8-1:0] mailboxes;
        // input buffer read data
        logic [7:0] cfg_rdata;
    } mhic_state_s;

    mhic_state_s state_reg;
    mhic_state_s state_next;
    mhic_pin_e pin_sel;
    logic int_en;
    logic int_pol;
    logic stream_en;
    logic ctrl_hit;
    logic ctrl_wr;
    logic app_ok;
    logic irq_level;

    // ******************************************************************
    // decode
    // ******************************************************************
    // control byte hit on the input buffer offset
    function automatic logic is_ctrl(input logic [MHIC_CFG_AW-1:0] a);
        is_ctrl = (a == MHIC_CTRL_CFG_OFFSET);
    endfunction

    // application write that may land in its mailbox
    function automatic logic app_lands(input logic wr,
                                       input logic quick_read,
                                       input logic stream);
        app_lands = wr && (!quick_read || stream);
    endfunction

    // level on the pin for a pending flag under a polarity
    function automatic logic irq_pin_level(input logic pend,
                                           input logic pol);
        irq_pin_level = pol ? pend : ~pend;
    endfunction

    // pending flag: set beats ack, disable beats both
    function automatic logic pend_update(input logic pend,
                                         input logic ack,
                                         input logic set,
                                         input logic enabled);
        logic nxt;
        nxt = pend;
        if (ack) begin
            nxt = 1'b0;
        end
        if (set) begin
            nxt = 1'b1;
        end
        if (!enabled) begin
            nxt = 1'b0;
        end
        pend_update = nxt;
    endfunction

    assign int_en = state_reg.ctrl_byte[MHIC_BIT_INT_EN];
    assign int_pol = state_reg.ctrl_byte[MHIC_BIT_INT_POL];
    assign stream_en = state_reg.ctrl_byte[MHIC_BIT_STREAM];
    assign ctrl_hit = is_ctrl(i_cfg_addr);
    assign ctrl_wr = i_cfg_wr && ctrl_hit;
    assign app_ok = app_lands(i_app_wr, i_app_quick_read, stream_en);

    // ******************************************************************
    // next state
    // ******************************************************************
    always_comb begin
        state_next = state_reg;
        if (ctrl_wr) begin
            state_next.ctrl_byte = i_cfg_wdata & MHIC_CTRL_CFG_MASK;
        end
        // readback shows the byte before a same-cycle write
        if (ctrl_hit) begin
            state_next.cfg_rdata = state_reg.ctrl_byte;
        end else begin
            state_next.cfg_rdata = MHIC_BYTE_ZERO;
        end
        if (app_ok) begin
            state_next.mailboxes[i_app_addr*8 +: 8] = i_app_wdata;
        end
        state_next.irq_pend = pend_update(state_reg.irq_pend,
                                          i_host_irq_ack,
                                          app_ok && int_en,
                                          state_next.ctrl_byte[MHIC_BIT_INT_EN]);
    end

    // ******************************************************************
    // state register
    // ******************************************************************
    // reset disables interrupts
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '0;
            state_reg.ctrl_byte <= MHIC_CTRL_CFG_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ******************************************************************
    // pin mux
    // ******************************************************************
    // enable bit drives mux
    assign pin_sel = int_en ? MHIC_PIN_IRQ : MHIC_PIN_GPIO;
    assign irq_level = irq_pin_level(state_reg.irq_pend, int_pol);

    always_comb begin
        case (pin_sel)
            MHIC_PIN_IRQ: begin
                o_pin_out = irq_level;
                o_pin_oe_n = 1'b0;
            end
            MHIC_PIN_GPIO: begin
                o_pin_out = i_gpio_out;
                o_pin_oe_n = i_gpio_oe_n;
            end
            default: begin
                o_pin_out = i_gpio_out;
                o_pin_oe_n = i_gpio_oe_n;
            end
        endcase
    end

    // ******************************************************************
    // outputs
    // ******************************************************************
    assign o_pin_irq_mode = (pin_sel == MHIC_PIN_IRQ);
    assign o_stream_en = stream_en;
    assign o_cfg_rdata = state_reg.cfg_rdata;

    // ******************************************************************
    // host read line buffer
    // ******************************************************************
    mhic_line_buffer mhic_line_buffer_i (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_mailboxes(state_reg.mailboxes),
        .i_rd(i_host_rd),
        .i_rd_addr(i_host_addr),
        .o_rd_data(o_host_rdata)
    );
endmodule // mhic_top

// ==== verification/mhic_host_model.sv ====
/* host side model: issues single mailbox byte reads
   returns with the data already registered, one cycle after the strobe */
`timescale 1ns/1ps
module mhic_host_model
    import mhic_pkg::*;
(
    input wire logic i_clk,
    output logic o_rd,
    output logic [MHIC_MB_AW-1:0] o_addr
);
    initial o_rd = 1'b0;
    initial o_addr = 5'h00;
    task automatic rd(input logic [MHIC_MB_AW-1:0] a);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
    endtask
endmodule // mhic_host_model

// ==== verification/mhic_top_asserts.sv ====
/* concurrent checks on the mhic_top ports
   assumes one clock and an async active-low reset */
`timescale 1ns/1ps
module mhic_top_chk
    import mhic_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_cfg_wr,
    input wire logic [MHIC_CFG_AW-1:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_wdata,
    input wire logic [7:0] o_cfg_rdata,
    input wire logic i_app_wr,
    input wire logic i_app_quick_read,
    input wire logic i_host_irq_ack,
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe_n,
    input wire logic o_pin_out,
    input wire logic o_pin_oe_n,
    input wire logic o_pin_irq_mode,
    input wire logic o_stream_en
);
    logic pol_q;
    wire logic wr56 = i_cfg_wr && i_cfg_addr == MHIC_CTRL_CFG_OFFSET;
    // polarity shadow, not visible at the ports
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) pol_q <= 1'b0;
        else if (wr56) pol_q <= i_cfg_wdata[1];
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ****
    // properties
    // ****
    property p_rst; disable iff (1'b0) $rose(i_reset_n) |-> !o_pin_irq_mode && !o_stream_en; endproperty
    a_rst: assert property (p_rst) else $error("enabled after reset");
    property p_mode; wr56 |=> o_pin_irq_mode == $past(i_cfg_wdata[0]); endproperty
    a_mode: assert property (p_mode) else $error("pin mode wrong");
    property p_strm; wr56 |=> o_stream_en == $past(i_cfg_wdata[2]); endproperty
    a_strm: assert property (p_strm) else $error("stream bit wrong");
    property p_oe; o_pin_irq_mode |-> !o_pin_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("pin not driven");
    property p_gpio; !o_pin_irq_mode |-> o_pin_out == i_gpio_out && o_pin_oe_n == i_gpio_oe_n; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio path wrong");
    property p_irq; o_pin_irq_mode && i_app_wr && !i_cfg_wr && (!i_app_quick_read || o_stream_en)
        |=> o_pin_out == pol_q; endproperty
    a_irq: assert property (p_irq) else $error("interrupt not asserted");
    property p_ack; o_pin_irq_mode && i_host_irq_ack && !i_app_wr && !i_cfg_wr |=> o_pin_out != pol_q; endproperty
    a_ack: assert property (p_ack) else $error("inactive level wrong");
    property p_off; i_cfg_wr && i_cfg_addr != MHIC_CTRL_CFG_OFFSET |=> $stable(o_stream_en) && $stable(o_pin_irq_mode);
    endproperty
    a_off: assert property (p_off) else $error("other offset changed control");
    property p_rdb; i_cfg_addr == MHIC_CTRL_CFG_OFFSET && !i_cfg_wr
        |=> o_cfg_rdata == {5'h00, o_stream_en, pol_q, o_pin_irq_mode}; endproperty
    a_rdb: assert property (p_rdb) else $error("control readback wrong");
    c_irq: cover property (o_pin_irq_mode && i_app_wr);
    c_qr: cover property (o_stream_en && i_app_wr && i_app_quick_read);
    c_ack: cover property (o_pin_irq_mode && i_host_irq_ack);
endmodule // mhic_top_chk
bind mhic_top mhic_top_chk mhic_top_chk_i (.i_clk, .i_reset_n, .i_cfg_wr, .i_cfg_addr, .i_cfg_wdata,
    .o_cfg_rdata, .i_app_wr, .i_app_quick_read, .i_host_irq_ack, .i_gpio_out, .i_gpio_oe_n, .o_pin_out,
    .o_pin_oe_n, .o_pin_irq_mode, .o_stream_en);

// ==== verification/tb_mailbox_host_irq_control.sv ====
/* self-checking bench for mhic_top
   assumes host model and checker compiled before it */
`timescale 1ns/1ps
module tb_mailbox_host_irq_control import mhic_pkg::*;;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_cfg_wr = 1'b0, i_app_wr = 1'b0, i_app_quick_read = 1'b0;
    logic i_gpio_out = 1'b0, i_gpio_oe_n = 1'b1, i_host_irq_ack = 1'b0, i_host_rd, q;
    logic o_pin_out, o_pin_oe_n, o_pin_irq_mode, o_stream_en;
    logic [5:0] i_cfg_addr = 6'h38;
    logic [4:0] i_app_addr = 5'h00, i_host_addr, a;
    logic [7:0] i_cfg_wdata = 8'h00, i_app_wdata = 8'h00, o_cfg_rdata, o_host_rdata, ctl = 8'h00, d;
    logic [7:0] mb [32];
    int fail_count = 0, check_count = 0, cyc = 0;
    always #50 i_clk = ~i_clk;
    mhic_top mhic_top_i (.i_clk, .i_reset_n, .i_cfg_wr, .i_cfg_addr, .i_cfg_wdata, .o_cfg_rdata, .i_app_wr,
        .i_app_addr, .i_app_wdata, .i_app_quick_read, .i_host_rd, .i_host_addr, .o_host_rdata, .i_gpio_out,
        .i_gpio_oe_n, .i_host_irq_ack, .o_pin_out, .o_pin_oe_n, .o_pin_irq_mode, .o_stream_en);
    mhic_host_model mhic_host_model_i (.i_clk, .o_rd(i_host_rd), .o_addr(i_host_addr));
    function automatic logic pin_exp(input logic pend);
        return ctl[0] ? (pend ~^ ctl[1]) : i_gpio_out;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cfg(input logic [5:0] ad, input logic [7:0] dt);
        @(posedge i_clk);
        {i_cfg_wr, i_cfg_addr, i_cfg_wdata} <= {1'b1, ad, dt};
        @(posedge i_clk);
        {i_cfg_wr, i_cfg_addr} <= {1'b0, 6'h38};
        if (ad == 6'h38) ctl = dt & 8'h07;
        @(posedge i_clk);
        #1;
    endtask
    task automatic app(input logic [4:0] ad, input logic [7:0] dt, input logic qr);
        @(posedge i_clk);
        {i_app_wr, i_app_addr, i_app_wdata, i_app_quick_read} <= {1'b1, ad, dt, qr};
        i_gpio_out <= ~i_gpio_out;
        i_gpio_oe_n <= 1'($urandom);
        @(posedge i_clk);
        i_app_wr <= 1'b0;
        #1;
        if (!qr || ctl[2]) mb[ad] = dt;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 5000) begin
            fail_count++;
            results;
        end
    end
    initial begin
        void'($urandom(49551));
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        chk("irq_mode", 8'h00, o_pin_irq_mode);
        chk("pin", i_gpio_out, o_pin_out);
        for (int i = 0; i < 32; i++) app(i[4:0], 8'($urandom), 1'b0);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            cfg(6'h38, {5'($urandom), i[2:0]});
            chk("mode", i[0], o_pin_irq_mode);
            chk("stream", i[2], o_stream_en);
            chk("cfg_rd", {5'h00, i[2:0]}, o_cfg_rdata);
            a = 5'($urandom) & 5'h1c;
            q = 1'($urandom);
            app(a, 8'($urandom), q);
            chk("irq", pin_exp(!q || ctl[2]), o_pin_out);
            chk("oe", ctl[0] ? 1'b0 : i_gpio_oe_n, o_pin_oe_n);
            mhic_host_model_i.rd(a);
            chk("rd", mb[a], o_host_rdata);
            @(posedge i_clk) i_host_irq_ack <= 1'b1;
            @(posedge i_clk) i_host_irq_ack <= 1'b0;
            #1;
            chk("ack", pin_exp(1'b0), o_pin_out);
            cfg({1'b0, 5'($urandom)}, 8'hff);
            chk("offset", i[2], o_stream_en);
        end
        $display("test control done");
        mhic_host_model_i.rd(5'h08);
        d = mb[9];
        app(5'h09, ~d, 1'b0);
        mhic_host_model_i.rd(5'h09);
        chk("line", d, o_host_rdata);
        mhic_host_model_i.rd(5'h0c);
        mhic_host_model_i.rd(5'h09);
        chk("relatch", mb[9], o_host_rdata);
        $display("test line buffer done");
        cfg(6'h38, 8'h07);
        app(5'h04, 8'h5a, 1'b0);
        @(posedge i_clk) i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        ctl = 8'h00;
        foreach (mb[k]) mb[k] = 8'h00;
        chk("rst_mode", 8'h00, o_pin_irq_mode);
        chk("rst_stream", 8'h00, o_stream_en);
        chk("rst_pin", i_gpio_out, o_pin_out);
        chk("rst_oe", i_gpio_oe_n, o_pin_oe_n);
        chk("rst_cfg_rd", 8'h00, o_cfg_rdata);
        mhic_host_model_i.rd(5'h04);
        chk("rst_rd", mb[4], o_host_rdata);
        $display("test mid reset done");
        results;
    end
endmodule // tb_mailbox_host_irq_control
